// *** logic/dcd_dev.sv ***
// memory end: serves the two descriptor words and takes the direct setting command
// assumes the link pins come from another clock domain
`timescale 1ns/10ps
`default_nettype none
`include "dcd_map.svh"
module dcd_dev
	import dcd_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// link
	dcd_link_if.dev link,
	// setting description
	input wire logic cfg_var_sup_in,
	input wire logic cfg_field_ok_in,
	input wire logic [1:0] cfg_wcode_in,
	input wire logic cfg_addr_mode_in,
	input wire logic cfg_addr_byte1_in,
	input wire logic [2:0] cfg_lsb_in,
	input wire logic [7:0] cfg_local_addr_in,
	input wire logic [3:0] cfg_flags_in,
	input wire logic [3:0] cfg_dummy_in,
	input wire logic [7:0] cfg_rd_op_in,
	input wire logic [7:0] cfg_wr_op_in,
	input wire logic cfg_sup30_in,
	input wire logic [4:0] cfg_pat30_in,
	input wire logic cfg_sup28_in,
	input wire logic [4:0] cfg_pat28_in,
	// setting bits
	output logic [4:0] setting_out,
	output logic setting_wr_out
);
	dcd_dstate_e state, next_state;
	logic [2:0] s_clk, s_cs, s_mosi;
	logic l_clk, l_cs, l_mosi, next_l_clk, next_l_cs, next_l_mosi;
	logic [2:0] cnt, next_cnt;
	logic [7:0] sh, next_sh;
	logic [63:0] out, next_out;
	logic miso, next_miso;
	logic [4:0] next_setting;
	logic next_setting_wr;
	logic [31:0] w10, w11;
	logic [4:0] mask;
	logic [7:0] byte_in;
	logic rise;

	assign link.miso = miso;

	always_comb begin
		mask = dcd_mask(cfg_wcode_in);
		w10 = {cfg_var_sup_in & cfg_field_ok_in,
			cfg_wcode_in, cfg_addr_mode_in, cfg_addr_byte1_in, cfg_lsb_in,
			cfg_addr_mode_in ? cfg_local_addr_in : {cfg_flags_in, cfg_dummy_in},
			cfg_rd_op_in, cfg_wr_op_in};
		w11 = {cfg_sup30_in, cfg_pat30_in & mask,
			cfg_sup28_in, cfg_pat28_in & mask, 20'h00000};
		next_l_clk = dcd_filt(s_clk, l_clk);
		next_l_cs = dcd_filt(s_cs, l_cs);
		next_l_mosi = dcd_filt(s_mosi, l_mosi);
		rise = !l_clk && next_l_clk;
		byte_in = {sh[6:0], l_mosi};
		next_state = state;
		next_cnt = cnt;
		next_sh = sh;
		next_out = out;
		next_miso = miso;
		next_setting = setting_out;
		next_setting_wr = 1'b0;
		if (l_cs) begin
			next_state = DCD_D_CMD;
			next_cnt = 3'h0;
			next_miso = 1'b0;
		end else if (rise) begin
			case (state)
				DCD_D_CMD: begin
					next_sh = byte_in;
					next_cnt = cnt + 3'h1;
					if (cnt == 3'h7) begin
						if (byte_in == `DCD_OP_TABLE) begin
							next_state = DCD_D_SEND;
							next_out = {w10, w11};
							next_miso = w10[31];
						end else if (byte_in == cfg_wr_op_in && cfg_wr_op_in != `DCD_OP_NONE
							&& !cfg_addr_mode_in) begin
							// data follows the opcode directly, no dummy cycles
							next_state = DCD_D_DATA;
						end else begin
							next_state = DCD_D_SKIP;
						end
					end
				end
				DCD_D_SEND: begin
					next_out = {out[62:0], 1'b0};
					next_miso = out[62];
				end
				DCD_D_DATA: begin
					next_sh = byte_in;
					next_cnt = cnt + 3'h1;
					if (cnt == 3'h7) begin
						next_setting = 5'(byte_in >> cfg_lsb_in) & mask;
						next_setting_wr = 1'b1;
						next_state = DCD_D_SKIP;
					end
				end
				DCD_D_SKIP: next_state = DCD_D_SKIP;
				default: next_state = DCD_D_CMD;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= DCD_D_CMD;
			s_clk <= 3'h0;
			s_cs <= 3'h7;
			s_mosi <= 3'h0;
			l_clk <= 1'b0;
			l_cs <= 1'b1;
			l_mosi <= 1'b0;
			cnt <= 3'h0;
			sh <= 8'h00;
			out <= 64'h0;
			miso <= 1'b0;
			setting_out <= 5'h00;
			setting_wr_out <= 1'b0;
		end else begin
			state <= next_state;
			s_clk <= {s_clk[1:0], link.sclk};
			s_cs <= {s_cs[1:0], link.cs_n};
			s_mosi <= {s_mosi[1:0], link.mosi};
			l_clk <= next_l_clk;
			l_cs <= next_l_cs;
			l_mosi <= next_l_mosi;
			cnt <= next_cnt;
			sh <= next_sh;
			out <= next_out;
			miso <= next_miso;
			setting_out <= next_setting;
			setting_wr_out <= next_setting_wr;
		end
	end
endmodule
`default_nettype wire

// *** logic/dcd_host.sv ***
// host end: reads both descriptor words after reset, decodes them and
// programs the dummy-cycle setting by the direct write command on request
// assumes the memory end answers on miso from its own clock domain
`timescale 1ns/10ps
`default_nettype none
`include "dcd_map.svh"
module dcd_host
	import dcd_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// link
	dcd_link_if.host link,
	// setting request
	input wire logic set_req_in,
	input wire logic [4:0] set_pattern_in,
	output logic set_done_out,
	output logic set_refused_out,
	// decoded location word
	output logic valid_out,
	output logic var_sup_out,
	output logic [2:0] nbits_out,
	output logic addr_mode_out,
	output logic addr_byte1_out,
	output logic [2:0] lsb_out,
	output logic [7:0] local_addr_out,
	output logic [3:0] flags_out,
	output logic [3:0] dummy_out,
	output logic [7:0] rd_op_out,
	output logic [7:0] wr_op_out,
	output logic rd_ok_out,
	output logic wr_ok_out,
	// decoded pattern word
	output logic sup30_out,
	output logic [4:0] pat30_out,
	output logic sup28_out,
	output logic [4:0] pat28_out
);
	localparam logic [3:0] HALF_LAST = 4'(`DCD_SCLK_HALF_CYC - 1);

	dcd_hstate_e state, next_state;
	dcd_fields_s f, next_f;
	logic [2:0] s_miso;
	logic l_miso, next_l_miso;
	logic [3:0] div, next_div;
	logic [6:0] bits, next_bits;
	logic [15:0] tx, next_tx;
	logic [63:0] rx, next_rx;
	logic sclk, next_sclk;
	logic cs_n, next_cs_n;
	logic mosi, next_mosi;
	logic table_rd, next_table_rd;
	logic valid, next_valid;
	logic next_done, next_refused;
	logic tick;
	logic [31:0] w10, w11;
	logic [4:0] mask;
	logic [7:0] data;

	assign link.sclk = sclk;
	assign link.cs_n = cs_n;
	assign link.mosi = mosi;

	assign valid_out = valid;
	assign var_sup_out = f.var_sup;
	assign nbits_out = f.nbits;
	assign addr_mode_out = f.addr_mode;
	assign addr_byte1_out = f.addr_byte1;
	assign lsb_out = f.lsb;
	assign local_addr_out = f.local_addr;
	assign flags_out = f.flags;
	assign dummy_out = f.dummy;
	assign rd_op_out = f.rd_op;
	assign wr_op_out = f.wr_op;
	assign rd_ok_out = f.rd_ok;
	assign wr_ok_out = f.wr_ok;
	assign sup30_out = f.sup30;
	assign pat30_out = f.pat30;
	assign sup28_out = f.sup28;
	assign pat28_out = f.pat28;

	always_comb begin
		next_l_miso = dcd_filt(s_miso, l_miso);
		tick = (div == HALF_LAST);
		w10 = rx[63:32];
		w11 = rx[31:0];
		mask = dcd_mask(w10[`DCD_W10_WID_HI:`DCD_W10_WID_LO]);
		data = 8'({3'h0, set_pattern_in & dcd_mask(f.wcode)} << f.lsb);
		next_state = state;
		next_f = f;
		next_div = div;
		next_bits = bits;
		next_tx = tx;
		next_rx = rx;
		next_sclk = sclk;
		next_cs_n = cs_n;
		next_mosi = mosi;
		next_table_rd = table_rd;
		next_valid = valid;
		next_done = 1'b0;
		next_refused = 1'b0;
		case (state)
			DCD_H_BOOT: begin
				next_state = DCD_H_XFER;
				next_cs_n = 1'b0;
				next_div = 4'h0;
				next_tx = {`DCD_OP_TABLE, 8'h00};
				next_mosi = 1'(`DCD_OP_TABLE >> 7);
				next_bits = `DCD_TABLE_BITS;
				next_table_rd = 1'b1;
			end
			DCD_H_XFER: begin
				next_div = tick ? 4'h0 : div + 4'h1;
				if (set_req_in) begin
					next_refused = 1'b1;
				end
				if (tick) begin
					if (sclk) begin
						next_sclk = 1'b0;
						next_tx = {tx[14:0], 1'b0};
						next_mosi = tx[14];
						if (bits == 7'h0) begin
							next_cs_n = 1'b1;
							next_mosi = 1'b0;
							next_state = DCD_H_END;
						end
					end else begin
						next_sclk = 1'b1;
						next_rx = {rx[62:0], l_miso};
						next_bits = bits - 7'h1;
					end
				end
			end
			DCD_H_END: begin
				next_state = DCD_H_IDLE;
				if (set_req_in) begin
					next_refused = 1'b1;
				end
				if (table_rd) begin
					next_f.var_sup = w10[`DCD_W10_SUP];
					next_f.wcode = w10[`DCD_W10_WID_HI:`DCD_W10_WID_LO];
					next_f.nbits = {1'b0, w10[`DCD_W10_WID_HI:`DCD_W10_WID_LO]}
						+ `DCD_WIDTH_BASE;
					next_f.addr_mode = w10[`DCD_W10_AMODE];
					next_f.addr_byte1 = w10[`DCD_W10_BYTE1];
					next_f.lsb = w10[`DCD_W10_LSB_HI:`DCD_W10_LSB_LO];
					if (w10[`DCD_W10_AMODE]) begin
						next_f.local_addr = w10[`DCD_W10_FLD_HI:`DCD_W10_FLD_LO];
						next_f.flags = 4'h0;
						next_f.dummy = 4'h0;
					end else begin
						next_f.local_addr = 8'h00;
						// a cleared flag is passed on as is, not read as absence
						next_f.flags = w10[`DCD_W10_FLD_HI:`DCD_W10_FLG_LO];
						next_f.dummy = w10[`DCD_W10_DUM_HI:`DCD_W10_FLD_LO];
					end
					next_f.rd_op = w10[`DCD_W10_RD_HI:`DCD_W10_RD_LO];
					next_f.wr_op = w10[`DCD_W10_WR_HI:`DCD_W10_WR_LO];
					next_f.rd_ok = w10[`DCD_W10_RD_HI:`DCD_W10_RD_LO] != `DCD_OP_NONE;
					next_f.wr_ok = w10[`DCD_W10_WR_HI:`DCD_W10_WR_LO] != `DCD_OP_NONE;
					next_f.sup30 = w11[`DCD_W11_S30];
					next_f.pat30 = w11[`DCD_W11_P30_HI:`DCD_W11_P30_LO] & mask;
					next_f.sup28 = w11[`DCD_W11_S28];
					next_f.pat28 = w11[`DCD_W11_P28_HI:`DCD_W11_P28_LO] & mask;
					next_valid = 1'b1;
				end else begin
					next_done = 1'b1;
				end
			end
			DCD_H_IDLE: begin
				if (set_req_in) begin
					// only a direct, supported write opcode may be issued
					if (!f.var_sup || !f.wr_ok || f.addr_mode) begin
						next_refused = 1'b1;
					end else begin
						next_state = DCD_H_XFER;
						next_cs_n = 1'b0;
						next_div = 4'h0;
						next_tx = {f.wr_op, data};
						next_mosi = f.wr_op[7];
						next_bits = `DCD_SET_BITS;
						next_table_rd = 1'b0;
					end
				end
			end
			default: next_state = DCD_H_BOOT;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= DCD_H_BOOT;
			f <= '0;
			s_miso <= 3'h0;
			l_miso <= 1'b0;
			div <= 4'h0;
			bits <= 7'h0;
			tx <= 16'h0000;
			rx <= 64'h0;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			mosi <= 1'b0;
			table_rd <= 1'b0;
			valid <= 1'b0;
			set_done_out <= 1'b0;
			set_refused_out <= 1'b0;
		end else begin
			state <= next_state;
			f <= next_f;
			s_miso <= {s_miso[1:0], link.miso};
			l_miso <= next_l_miso;
			div <= next_div;
			bits <= next_bits;
			tx <= next_tx;
			rx <= next_rx;
			sclk <= next_sclk;
			cs_n <= next_cs_n;
			mosi <= next_mosi;
			table_rd <= next_table_rd;
			valid <= next_valid;
			set_done_out <= next_done;
			set_refused_out <= next_refused;
		end
	end
endmodule
`default_nettype wire

// *** logic/dcd_link_if.sv ***
// link between the descriptor reader and the memory holding the descriptor words
// assumes the host makes the link clock; both ends sit on their own system clock
`timescale 1ns/10ps
`default_nettype none
interface dcd_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;

	modport host (
		output sclk,
		output cs_n,
		output mosi,
		input miso
	);

	modport dev (
		input sclk,
		input cs_n,
		input mosi,
		output miso
	);
endinterface
`default_nettype wire

// *** logic/dcd_map.svh ***
// offsets, field positions, opcodes and timing counts of the dummy-cycle descriptor link
// assumes a 50 MHz system clock on both ends
//
// What this block does
// - Support flag zero unless field contiguous, ordered
// - Addressed mode: bits 23-16 give register address
// - Direct mode: bits 23-20 are mode flags
// - Direct mode: bits 19-16 give dummy count
// - Setting command accepted single-lane without dummy cycles
// - Cleared mode flag does not mean unavailable
// - Read opcode 00h means no read command
// - Write opcode 00h means no write command
// - Pattern word bit 31: 30 cycles supported
// - Bits 30-26 select 30 dummy cycles
// - Short patterns right-justified, upper bits zero
// - Pattern word bit 25: 28 cycles supported
// - Bits 30-29 give setting field width
// - Bit 28 selects direct or addressed access
// - Bit 27 selects address byte 0 or 1
// - Bits 26-24 give setting field LSB position
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH

// location descriptor word
`define DCD_W10_SUP 31
`define DCD_W10_WID_HI 30
`define DCD_W10_WID_LO 29
`define DCD_W10_AMODE 28
`define DCD_W10_BYTE1 27
`define DCD_W10_LSB_HI 26
`define DCD_W10_LSB_LO 24
`define DCD_W10_FLD_HI 23
`define DCD_W10_FLD_LO 16
`define DCD_W10_FLG_LO 20
`define DCD_W10_DUM_HI 19
`define DCD_W10_RD_HI 15
`define DCD_W10_RD_LO 8
`define DCD_W10_WR_HI 7
`define DCD_W10_WR_LO 0

// bit-pattern descriptor word
`define DCD_W11_S30 31
`define DCD_W11_P30_HI 30
`define DCD_W11_P30_LO 26
`define DCD_W11_S28 25
`define DCD_W11_P28_HI 24
`define DCD_W11_P28_LO 20

// link commands
`define DCD_OP_TABLE 8'ha5
`define DCD_OP_NONE 8'h00

// transfer lengths in link clock bits, and the base of the setting field width
`define DCD_TABLE_BITS 7'h48
`define DCD_SET_BITS 7'h10
`define DCD_WIDTH_BASE 3'h2

// timing
`define DCD_CLK_NS 20
`define DCD_SCLK_HALF_NS 160
`define DCD_SCLK_HALF_CYC ((`DCD_SCLK_HALF_NS + `DCD_CLK_NS - 1) / `DCD_CLK_NS)

`endif

// *** logic/dcd_pkg.sv ***
// types and shared helpers of the dummy-cycle descriptor link
// assumes dcd_map.svh is on the include path
`default_nettype none
package dcd_pkg;

	typedef enum logic [1:0] {
		DCD_H_BOOT,
		DCD_H_XFER,
		DCD_H_END,
		DCD_H_IDLE
	} dcd_hstate_e;

	typedef enum logic [1:0] {
		DCD_D_CMD,
		DCD_D_SEND,
		DCD_D_DATA,
		DCD_D_SKIP
	} dcd_dstate_e;

	typedef struct packed {
		logic var_sup;
		logic [1:0] wcode;
		logic [2:0] nbits;
		logic addr_mode;
		logic addr_byte1;
		logic [2:0] lsb;
		logic [7:0] local_addr;
		logic [3:0] flags;
		logic [3:0] dummy;
		logic [7:0] rd_op;
		logic [7:0] wr_op;
		logic rd_ok;
		logic wr_ok;
		logic sup30;
		logic [4:0] pat30;
		logic sup28;
		logic [4:0] pat28;
	} dcd_fields_s;

	// mask of the setting bits in use for a width code
	function automatic logic [4:0] dcd_mask(input logic [1:0] code);
		case (code)
			2'h0: dcd_mask = 5'h03;
			2'h1: dcd_mask = 5'h07;
			2'h2: dcd_mask = 5'h0f;
			default: dcd_mask = 5'h1f;
		endcase
	endfunction

	// filtered level: changes once the last two stages agree
	function automatic logic dcd_filt(input logic [2:0] sync, input logic lvl);
		dcd_filt = (sync[2] == sync[1]) ? sync[2] : lvl;
	endfunction

endpackage
`default_nettype wire

// *** verif/dcd_link_props.sv ***
// link checker: timing and framing of the descriptor link seen on the wire
// assumes both ends share clk_in and rst_n_in, and that the host makes sclk
`timescale 1ns/10ps
`default_nettype none
module dcd_link_props (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso
);
	logic prev_sclk;
	logic next_prev_sclk;
	logic [6:0] rises;
	logic [6:0] next_rises;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// rising edges of sclk seen within the current frame
	always_comb begin
		next_prev_sclk = sclk;
		next_rises = rises;
		if (cs_n) begin
			next_rises = 7'h00;
		end else if (sclk && !prev_sclk) begin
			next_rises = rises + 7'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_sclk <= 1'b0;
			rises <= 7'h00;
		end else begin
			prev_sclk <= next_prev_sclk;
			rises <= next_rises;
		end
	end

	property p_cs_idle_clk;
		cs_n |-> !sclk;
	endproperty
	a_cs_idle_clk: assert property (p_cs_idle_clk) else $error("sclk high while deselected");

	property p_miso_idle;
		cs_n [*6] |-> !miso;
	endproperty
	a_miso_idle: assert property (p_miso_idle) else $error("miso not low while deselected");

	property p_high_half;
		$rose(sclk) |-> sclk [*8] ##1 !sclk;
	endproperty
	a_high_half: assert property (p_high_half) else $error("sclk high half not 8 cycles");

	property p_low_half;
		$fell(sclk) |-> !sclk [*8];
	endproperty
	a_low_half: assert property (p_low_half) else $error("sclk low half under 8 cycles");

	property p_mosi_hold;
		(sclk && $past(sclk)) |-> $stable(mosi);
	endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");

	property p_cs_lead;
		$fell(cs_n) |-> !sclk [*8] ##1 sclk;
	endproperty
	a_cs_lead: assert property (p_cs_lead) else $error("first sclk rise not 8 cycles after select");

	// deselect comes with the last fall, closing a full 8-cycle high half
	property p_cs_tail;
		$rose(cs_n) |-> $past(sclk) && $past(sclk, 8) && !$past(sclk, 9);
	endproperty
	a_cs_tail: assert property (p_cs_tail) else $error("deselect not with last sclk fall");

	property p_frame_len;
		$rose(cs_n) |-> (rises == 7'h48) || (rises == 7'h10);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length not 72 or 16 bits");
endmodule
`default_nettype wire

// *** verif/tb_dummy_cycle_param_decoder.sv ***
// self-checking bench: host end and memory end joined by the link interface
// assumes both ends run on one 50 MHz clock and are reset together
`timescale 1ns/10ps
`default_nettype none
module tb_dummy_cycle_param_decoder
	import dcd_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic set_req = 1'b0;
	logic [4:0] set_pat = 5'h00;
	logic field_ok = 1'b1;
	dcd_fields_s cfg = '0;
	logic valid, var_sup, addr_mode, byte1, rd_ok, wr_ok, sup30, sup28, done, refused, set_wr;
	logic [2:0] nbits, lsb;
	logic [7:0] local_addr, rd_op, wr_op;
	logic [3:0] flags, dummy;
	logic [4:0] pat30, pat28, setting;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;

	dcd_link_if link();

	dcd_host i_dcd_host(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
		.set_req_in(set_req), .set_pattern_in(set_pat), .set_done_out(done),
		.set_refused_out(refused), .valid_out(valid), .var_sup_out(var_sup),
		.nbits_out(nbits), .addr_mode_out(addr_mode), .addr_byte1_out(byte1),
		.lsb_out(lsb), .local_addr_out(local_addr), .flags_out(flags),
		.dummy_out(dummy), .rd_op_out(rd_op), .wr_op_out(wr_op), .rd_ok_out(rd_ok),
		.wr_ok_out(wr_ok), .sup30_out(sup30), .pat30_out(pat30), .sup28_out(sup28),
		.pat28_out(pat28));

	dcd_dev i_dcd_dev(.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
		.cfg_var_sup_in(cfg.var_sup), .cfg_field_ok_in(field_ok),
		.cfg_wcode_in(cfg.wcode), .cfg_addr_mode_in(cfg.addr_mode),
		.cfg_addr_byte1_in(cfg.addr_byte1), .cfg_lsb_in(cfg.lsb),
		.cfg_local_addr_in(cfg.local_addr), .cfg_flags_in(cfg.flags),
		.cfg_dummy_in(cfg.dummy), .cfg_rd_op_in(cfg.rd_op), .cfg_wr_op_in(cfg.wr_op),
		.cfg_sup30_in(cfg.sup30), .cfg_pat30_in(cfg.pat30), .cfg_sup28_in(cfg.sup28),
		.cfg_pat28_in(cfg.pat28), .setting_out(setting), .setting_wr_out(set_wr));

	dcd_link_props i_dcd_link_props(.clk_in(clk_in), .rst_n_in(rst_n_in),
		.sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

	initial begin
		forever #10 clk_in = ~clk_in;
	end

	// hang guard: four cases need about 5000 cycles
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			bad_count = bad_count + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checked %0d, bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	// one-cycle request, then watch the pulses until done or refused
	task automatic set_try(input logic [4:0] pat, output logic d, output logic r, output logic w);
		int i;
		d = 1'b0;
		r = 1'b0;
		w = 1'b0;
		@(negedge clk_in);
		set_req = 1'b1;
		set_pat = pat;
		@(negedge clk_in);
		set_req = 1'b0;
		for (i = 0; i < 400; i++) begin
			d = d | (done === 1'b1);
			r = r | (refused === 1'b1);
			w = w | (set_wr === 1'b1);
			if (d || r) begin
				break;
			end
			@(negedge clk_in);
		end
	endtask

	task automatic run_case(input dcd_fields_s c, input logic fok, input logic [4:0] pat);
		logic [4:0] m;
		logic d, r, w, ok;
		int i;
		cfg = c;
		field_ok = fok;
		m = 5'((6'h04 << c.wcode) - 6'h01);
		ok = c.var_sup & fok & (c.wr_op != 8'h00) & !c.addr_mode;
		rst_n_in = 1'b0;
		repeat (4) @(negedge clk_in);
		rst_n_in = 1'b1;
		cmp("valid early", 8'(valid), 8'h00);
		set_try(pat, d, r, w);
		cmp("early refusal", 8'(r), 8'h01);
		for (i = 0; i < 2000 && valid !== 1'b1; i++) begin
			@(negedge clk_in);
		end
		cmp("valid", 8'(valid), 8'h01);
		cmp("var_sup", 8'(var_sup), 8'(c.var_sup & fok));
		cmp("nbits", 8'(nbits), 8'(c.wcode) + 8'h02);
		cmp("addr_mode", 8'(addr_mode), 8'(c.addr_mode));
		cmp("addr_byte1", 8'(byte1), 8'(c.addr_byte1));
		cmp("lsb", 8'(lsb), 8'(c.lsb));
		cmp("local_addr", local_addr, c.addr_mode ? c.local_addr : 8'h00);
		cmp("flags", 8'(flags), c.addr_mode ? 8'h00 : 8'(c.flags));
		cmp("dummy", 8'(dummy), c.addr_mode ? 8'h00 : 8'(c.dummy));
		cmp("rd_op", rd_op, c.rd_op);
		cmp("rd_ok", 8'(rd_ok), 8'(c.rd_op != 8'h00));
		cmp("wr_op", wr_op, c.wr_op);
		cmp("wr_ok", 8'(wr_ok), 8'(c.wr_op != 8'h00));
		cmp("sup30", 8'(sup30), 8'(c.sup30));
		cmp("pat30", 8'(pat30), 8'(c.pat30 & m));
		cmp("sup28", 8'(sup28), 8'(c.sup28));
		cmp("pat28", 8'(pat28), 8'(c.pat28 & m));
		set_try(pat, d, r, w);
		cmp("set done", 8'(d), 8'(ok));
		cmp("set refused", 8'(r), 8'(!ok));
		cmp("setting pulse", 8'(w), 8'(ok));
		if (ok) begin
			cmp("setting", 8'(setting), (8'(8'(pat & m) << c.lsb) >> c.lsb) & 8'(m));
		end
	endtask

	initial begin
		// direct mode, 5-bit field at bit 6: the pattern is cut to 8 bits
		run_case('{1'b1, 2'h3, 3'h0, 1'b0, 1'b0, 3'h6, 8'h5a, 4'ha, 4'hc, 8'h00, 8'h71,
			1'b0, 1'b0, 1'b1, 5'h13, 1'b0, 5'h0e}, 1'b1, 5'h1b);
		// addressed mode: no direct write possible
		run_case('{1'b1, 2'h1, 3'h0, 1'b1, 1'b1, 3'h2, 8'h5a, 4'h5, 4'h3, 8'h85, 8'h72,
			1'b0, 1'b0, 1'b0, 5'h1f, 1'b1, 5'h1d}, 1'b1, 5'h05);
		// field not describable: support flag must read 0
		run_case('{1'b1, 2'h2, 3'h0, 1'b0, 1'b0, 3'h1, 8'h00, 4'hf, 4'h0, 8'h0b, 8'h0c,
			1'b0, 1'b0, 1'b1, 5'h1f, 1'b1, 5'h10}, 1'b0, 5'h09);
		// write opcode 00h: request must be refused
		run_case('{1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 3'h0, 8'h00, 4'h0, 4'hf, 8'h3c, 8'h00,
			1'b0, 1'b0, 1'b0, 5'h00, 1'b1, 5'h1f}, 1'b1, 5'h02);
		give_verdict();
	end
endmodule
`default_nettype wire
